// file: csa_attitude_regs.sv
/*
  Register front end of the calibrated measurement and attitude bank: an
  Avalon-MM slave with waitrequest, group capture of measurements with their
  stamps, a freeze control and a status word.
  Assumes measurement producers on the same clock that pulse a valid for
  one cycle with the whole group steady on their ports.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: temperature float in Celsius at 0x5F
// RL2: temperature time stamp float at 0x60
// RL3: calibrated rate X, Y, Z at 0x61-0x63
// RL4: rate time stamp float at 0x64
// RL5: calibrated acceleration X, Y, Z at 0x65-0x67
// RL6: acceleration time stamp float at 0x68
// RL7: calibrated magnetic field X, Y, Z 0x69-0x6B
// RL8: magnetic field time stamp at 0x6C
// RL9: quaternion first/second halves at 0x6D
// RL10: quaternion fields scaled by 29789.09091
// RL11: quaternion third/fourth halves at 0x6E
// RL12: quaternion time stamp float at 0x6F
// RL13: roll/pitch halves at 0x70, angle scale
// RL14: yaw upper half at 0x71, low unused
// RL15: roll/pitch rates at 0x72, scale 16
// RL16: yaw rate upper half 0x73, low unused
// RL17: floats are 32-bit, most significant byte first
// RL18: bank read-only, writes ignored, unused zero
// RL19: group and stamp update together, never torn
module csa_attitude_regs (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // avalon-mm slave
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  // temperature group
  input wire logic temp_valid_in,
  input wire logic [31:0] temp_celsius_in,
  input wire logic [31:0] temp_stamp_in,
  // calibrated angular rate group
  input wire logic rate_valid_in,
  input wire logic [31:0] rate_x_in,
  input wire logic [31:0] rate_y_in,
  input wire logic [31:0] rate_z_in,
  input wire logic [31:0] rate_stamp_in,
  // calibrated acceleration group
  input wire logic accel_valid_in,
  input wire logic [31:0] accel_x_in,
  input wire logic [31:0] accel_y_in,
  input wire logic [31:0] accel_z_in,
  input wire logic [31:0] accel_stamp_in,
  // calibrated magnetic field group
  input wire logic field_valid_in,
  input wire logic [31:0] field_x_in,
  input wire logic [31:0] field_y_in,
  input wire logic [31:0] field_z_in,
  input wire logic [31:0] field_stamp_in,
  // quaternion estimate group, pre-scaled signed halves
  input wire logic quat_valid_in,
  input wire logic [15:0] quat_a_in,
  input wire logic [15:0] quat_b_in,
  input wire logic [15:0] quat_c_in,
  input wire logic [15:0] quat_d_in,
  input wire logic [31:0] quat_stamp_in,
  // euler estimate group, pre-scaled signed halves
  input wire logic euler_valid_in,
  input wire logic [15:0] roll_angle_in,
  input wire logic [15:0] pitch_angle_in,
  input wire logic [15:0] heading_angle_in,
  input wire logic [15:0] roll_rate_in,
  input wire logic [15:0] pitch_rate_in,
  input wire logic [15:0] heading_rate_in
);

  // slot numbers of the bank words, fixed at elaboration
  localparam logic [4:0] S_TEMP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_TEMP);
  localparam logic [4:0] S_TSTAMP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_TEMP_STAMP);
  localparam logic [4:0] S_RX = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_RATE_X);
  localparam logic [4:0] S_RY = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_RATE_Y);
  localparam logic [4:0] S_RZ = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_RATE_Z);
  localparam logic [4:0] S_RSTAMP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_RATE_STAMP);
  localparam logic [4:0] S_AX = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_ACCEL_X);
  localparam logic [4:0] S_AY = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_ACCEL_Y);
  localparam logic [4:0] S_AZ = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_ACCEL_Z);
  localparam logic [4:0] S_ASTAMP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_ACCEL_STAMP);
  localparam logic [4:0] S_FX = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_FIELD_X);
  localparam logic [4:0] S_FY = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_FIELD_Y);
  localparam logic [4:0] S_FZ = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_FIELD_Z);
  localparam logic [4:0] S_FSTAMP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_FIELD_STAMP);
  localparam logic [4:0] S_Q1 = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_Q_FIRST);
  localparam logic [4:0] S_Q2 = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_Q_SECOND);
  localparam logic [4:0] S_QSTAMP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_Q_STAMP);
  localparam logic [4:0] S_RP = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_ROLL_PITCH);
  localparam logic [4:0] S_HD = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_HEADING);
  localparam logic [4:0] S_RPR = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_RP_RATES);
  localparam logic [4:0] S_HDR = csa_regs_pkg::csa_slot(
    csa_regs_pkg::CSA_IDX_HEAD_RATE);
  localparam int NG = csa_regs_pkg::CSA_GROUPS;

  // bus state
  logic waitrequest_r; // high except in the one answer cycle
  logic [31:0] readdata_r; // captured read word
  logic [1:0] response_r; // captured answer code
  logic [7:0] rd_idx; // word index of the request
  logic take; // request accepted at this edge
  logic [31:0] rd_word; // read mux output
  logic [1:0] rd_resp; // answer code for the current index

  // control and status state
  logic freeze_r; // host holds the bank still for a coherent scan
  logic [NG-1:0] fresh_r; // group loaded since last status read
  logic [NG-1:0] missed_r; // group update dropped while frozen
  logic [NG-1:0] grp_valid; // producer strobes, one per group
  logic [NG-1:0] grp_ld; // strobes that really load the bank
  logic stat_clr; // status word read this edge

  // word store behind the carrier
  csa_bank_if #(.WORDS(csa_regs_pkg::CSA_BANK_WORDS)) bank_if (
    .clk(sys_clk_in),
    .rst_n(reset_n_in)
  );
  csa_word_bank #(.WORDS(csa_regs_pkg::CSA_BANK_WORDS)) u_csa_word_bank (
    .bank(bank_if)
  );

  // gather producer strobes in group order
  always_comb begin
    grp_valid = '0;
    grp_valid[csa_regs_pkg::CSA_GRP_TEMP] = temp_valid_in;
    grp_valid[csa_regs_pkg::CSA_GRP_RATE] = rate_valid_in;
    grp_valid[csa_regs_pkg::CSA_GRP_ACCEL] = accel_valid_in;
    grp_valid[csa_regs_pkg::CSA_GRP_FIELD] = field_valid_in;
    grp_valid[csa_regs_pkg::CSA_GRP_QUAT] = quat_valid_in;
    grp_valid[csa_regs_pkg::CSA_GRP_EULER] = euler_valid_in;
  end

  // a freeze drops updates rather than queueing them: no buffer, and the
  // host sees the loss in the missed bits
  assign grp_ld = grp_valid & {NG{~freeze_r}}; // [RL19]

  // every word of a group loads on the same strobe as its stamp
  always_comb begin
    bank_if.load = '0;
    for (int s = 0; s < csa_regs_pkg::CSA_BANK_WORDS; s++) begin
      bank_if.load[s] = grp_ld[csa_regs_pkg::csa_group_of(5'(s))]; // [RL19]
    end
  end

  // next words: floats pass bit for bit, halves are packed high then low
  always_comb begin
    bank_if.din = '0;
    bank_if.din[S_TEMP] = temp_celsius_in; // [RL1]
    bank_if.din[S_TSTAMP] = temp_stamp_in; // [RL2]
    bank_if.din[S_RX] = rate_x_in; // [RL3]
    bank_if.din[S_RY] = rate_y_in; // [RL3]
    bank_if.din[S_RZ] = rate_z_in; // [RL3]
    bank_if.din[S_RSTAMP] = rate_stamp_in; // [RL4]
    bank_if.din[S_AX] = accel_x_in; // [RL5]
    bank_if.din[S_AY] = accel_y_in; // [RL5]
    bank_if.din[S_AZ] = accel_z_in; // [RL5]
    bank_if.din[S_ASTAMP] = accel_stamp_in; // [RL6]
    bank_if.din[S_FX] = field_x_in; // [RL7]
    bank_if.din[S_FY] = field_y_in; // [RL7]
    bank_if.din[S_FZ] = field_z_in; // [RL7]
    bank_if.din[S_FSTAMP] = field_stamp_in; // [RL8]
    // halves arrive already multiplied by the quaternion scale [RL10]
    bank_if.din[S_Q1] = {quat_a_in, quat_b_in}; // [RL9]
    bank_if.din[S_Q2] = {quat_c_in, quat_d_in}; // [RL11]
    bank_if.din[S_QSTAMP] = quat_stamp_in; // [RL12]
    bank_if.din[S_RP] = {roll_angle_in, pitch_angle_in}; // [RL13]
    bank_if.din[S_HD] = {heading_angle_in,
                         csa_regs_pkg::CSA_UNUSED_HALF}; // [RL14]
    bank_if.din[S_RPR] = {roll_rate_in, pitch_rate_in}; // [RL15]
    bank_if.din[S_HDR] = {heading_rate_in,
                          csa_regs_pkg::CSA_UNUSED_HALF}; // [RL16]
  end

  // word index from the byte address; low two bits ignored
  assign rd_idx = avs_address_in[9:2];

  // a request is taken only while waitrequest is high, so the answer
  // cycle can never re-take the same request
  assign take = (avs_read_in || avs_write_in) && waitrequest_r;

  // read mux and decode; unmapped indices read zero with a decode error
  always_comb begin
    rd_word = '0;
    rd_resp = csa_regs_pkg::CSA_RSP_OKAY;
    if (csa_regs_pkg::csa_in_bank(rd_idx)) begin
      // word goes out whole: avalon lane 3 carries the top byte [RL17]
      rd_word = bank_if.dout[csa_regs_pkg::csa_slot(rd_idx)];
    end else if (rd_idx == csa_regs_pkg::CSA_IDX_CTRL) begin
      rd_word[csa_regs_pkg::CSA_CTRL_FREEZE_BIT] = freeze_r;
    end else if (rd_idx == csa_regs_pkg::CSA_IDX_STAT) begin
      rd_word[csa_regs_pkg::CSA_STAT_FRESH_LSB +: NG] = fresh_r;
      rd_word[csa_regs_pkg::CSA_STAT_MISSED_LSB +: NG] = missed_r;
      rd_word[csa_regs_pkg::CSA_STAT_FREEZE_BIT] = freeze_r;
    end else begin
      rd_resp = csa_regs_pkg::CSA_RSP_DECERR;
    end
  end

  // waitrequest drops for exactly one cycle after each taken request
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      waitrequest_r <= csa_regs_pkg::CSA_WAIT_RST;
    end else begin
      waitrequest_r <= !take;
    end
  end

  // read word and answer code are caught at the taking edge
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      readdata_r <= csa_regs_pkg::CSA_WORD_RST;
      response_r <= csa_regs_pkg::CSA_RSP_OKAY;
    end else if (take) begin
      readdata_r <= avs_read_in ? rd_word : csa_regs_pkg::CSA_WORD_RST;
      response_r <= rd_resp;
    end
  end

  // only the control word accepts writes; bank writes fall away [RL18]
  // the write lands at the accepting edge, while the master still holds
  // it, so a master that sees waitrequest high has committed nothing yet
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      freeze_r <= csa_regs_pkg::CSA_FREEZE_RST;
    end else if (avs_write_in && !waitrequest_r &&
                 rd_idx == csa_regs_pkg::CSA_IDX_CTRL) begin
      freeze_r <= avs_writedata_in[csa_regs_pkg::CSA_CTRL_FREEZE_BIT];
    end
  end

  // status read clears the sticky bits
  assign stat_clr = take && avs_read_in &&
                    (rd_idx == csa_regs_pkg::CSA_IDX_STAT);

  // sticky flags: a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      fresh_r <= '0;
      missed_r <= '0;
    end else begin
      fresh_r <= (stat_clr ? '0 : fresh_r) | grp_ld;
      missed_r <= (stat_clr ? '0 : missed_r) | (grp_valid & ~grp_ld);
    end
  end

  // outputs straight from flops
  assign avs_readdata_out = readdata_r;
  assign avs_waitrequest_out = waitrequest_r;
  assign avs_response_out = response_r;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // request taken, then the one-cycle answer window
  sequence s_take_rd(logic [7:0] i);
    avs_read_in && waitrequest_r && (rd_idx == i);
  endsequence
  sequence s_answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  AST_TEMP_READ: assert property ( // [RL1] [RL17]
    s_take_rd(csa_regs_pkg::CSA_IDX_TEMP) |=> s_answer and
    (avs_readdata_out[31:24] == $past(bank_if.dout[S_TEMP][31:24])) and
    (avs_readdata_out == $past(bank_if.dout[S_TEMP])))
    else $error("temperature read word or timing wrong");

  AST_TEMP_PAIR: assert property ( // [RL2]
    grp_ld[csa_regs_pkg::CSA_GRP_TEMP] |=>
    bank_if.dout[S_TEMP] == $past(temp_celsius_in) &&
    bank_if.dout[S_TSTAMP] == $past(temp_stamp_in))
    else $error("temperature and stamp not loaded together");

  AST_RATE_LOAD: assert property ( // [RL3] [RL4]
    grp_ld[csa_regs_pkg::CSA_GRP_RATE] |=>
    bank_if.dout[S_RX] == $past(rate_x_in) &&
    bank_if.dout[S_RZ] == $past(rate_z_in) &&
    bank_if.dout[S_RSTAMP] == $past(rate_stamp_in))
    else $error("rate group not loaded whole");

  AST_ACCEL_LOAD: assert property ( // [RL5] [RL6]
    grp_ld[csa_regs_pkg::CSA_GRP_ACCEL] |=>
    bank_if.dout[S_AY] == $past(accel_y_in) &&
    bank_if.dout[S_ASTAMP] == $past(accel_stamp_in))
    else $error("acceleration group not loaded whole");

  AST_FIELD_LOAD: assert property ( // [RL7] [RL8]
    grp_ld[csa_regs_pkg::CSA_GRP_FIELD] |=>
    bank_if.dout[S_FX] == $past(field_x_in) &&
    bank_if.dout[S_FSTAMP] == $past(field_stamp_in))
    else $error("field group not loaded whole");

  AST_QUAT_PACK: assert property ( // [RL9] [RL11] [RL12]
    grp_ld[csa_regs_pkg::CSA_GRP_QUAT] |=>
    bank_if.dout[S_Q1][31:16] == $past(quat_a_in) &&
    bank_if.dout[S_Q1][15:0] == $past(quat_b_in) &&
    bank_if.dout[S_Q2] == {$past(quat_c_in), $past(quat_d_in)} &&
    bank_if.dout[S_QSTAMP] == $past(quat_stamp_in))
    else $error("quaternion halves misplaced");

  AST_EULER_PACK: assert property ( // [RL13] [RL14] [RL15] [RL16]
    grp_ld[csa_regs_pkg::CSA_GRP_EULER] |=>
    bank_if.dout[S_RP] == {$past(roll_angle_in), $past(pitch_angle_in)} &&
    bank_if.dout[S_HD][31:16] == $past(heading_angle_in) &&
    bank_if.dout[S_HD][15:0] == csa_regs_pkg::CSA_UNUSED_HALF &&
    bank_if.dout[S_RPR][31:16] == $past(roll_rate_in) &&
    bank_if.dout[S_RPR][15:0] == $past(pitch_rate_in) &&
    bank_if.dout[S_HDR] == {$past(heading_rate_in),
                            csa_regs_pkg::CSA_UNUSED_HALF})
    else $error("euler halves misplaced");

  AST_RO_WRITE: assert property ( // [RL18]
    (take && avs_write_in && csa_regs_pkg::csa_in_bank(rd_idx) &&
     grp_ld == '0) |=> $stable(bank_if.dout) ##1 avs_waitrequest_out)
    else $error("bank write changed a word");

  AST_FROZEN: assert property ( // [RL19]
    freeze_r [*2] |-> $stable(bank_if.dout) && fresh_r == $past(fresh_r) ||
    $past(stat_clr))
    else $error("bank moved while frozen");

  AST_CTRL_WRITE: assert property ( // [RL18]
    (avs_write_in && !waitrequest_r &&
     rd_idx == csa_regs_pkg::CSA_IDX_CTRL) |=>
    freeze_r == $past(avs_writedata_in[csa_regs_pkg::CSA_CTRL_FREEZE_BIT]))
    else $error("control write did not land at the accepting edge");

endmodule : csa_attitude_regs
`default_nettype wire

// file: csa_regs_pkg.sv
/*
  Shared constants for the calibrated-measurement and attitude register bank:
  word indices, bank layout, group numbering, field positions, reset values
  and bus answer codes.
  Assumes a 32-bit Avalon-MM slave with byte addressing, one word per index.
*/
package csa_regs_pkg;

  // bus geometry
  localparam int CSA_ADDR_W = 10;
  localparam int CSA_DATA_W = 32;
  localparam int CSA_HALF_W = 16;

  // word indices of the bank; byte address is four times the index
  localparam logic [7:0] CSA_IDX_TEMP = 8'h5f;
  localparam logic [7:0] CSA_IDX_TEMP_STAMP = 8'h60;
  localparam logic [7:0] CSA_IDX_RATE_X = 8'h61;
  localparam logic [7:0] CSA_IDX_RATE_Y = 8'h62;
  localparam logic [7:0] CSA_IDX_RATE_Z = 8'h63;
  localparam logic [7:0] CSA_IDX_RATE_STAMP = 8'h64;
  localparam logic [7:0] CSA_IDX_ACCEL_X = 8'h65;
  localparam logic [7:0] CSA_IDX_ACCEL_Y = 8'h66;
  localparam logic [7:0] CSA_IDX_ACCEL_Z = 8'h67;
  localparam logic [7:0] CSA_IDX_ACCEL_STAMP = 8'h68;
  localparam logic [7:0] CSA_IDX_FIELD_X = 8'h69;
  localparam logic [7:0] CSA_IDX_FIELD_Y = 8'h6a;
  localparam logic [7:0] CSA_IDX_FIELD_Z = 8'h6b;
  localparam logic [7:0] CSA_IDX_FIELD_STAMP = 8'h6c;
  localparam logic [7:0] CSA_IDX_Q_FIRST = 8'h6d;
  localparam logic [7:0] CSA_IDX_Q_SECOND = 8'h6e;
  localparam logic [7:0] CSA_IDX_Q_STAMP = 8'h6f;
  localparam logic [7:0] CSA_IDX_ROLL_PITCH = 8'h70;
  localparam logic [7:0] CSA_IDX_HEADING = 8'h71;
  localparam logic [7:0] CSA_IDX_RP_RATES = 8'h72;
  localparam logic [7:0] CSA_IDX_HEAD_RATE = 8'h73;
  // control and status words added beside the bank
  localparam logic [7:0] CSA_IDX_CTRL = 8'hf0;
  localparam logic [7:0] CSA_IDX_STAT = 8'hf1;

  // bank size and measurement groups
  localparam int CSA_BANK_WORDS = 21;
  localparam int CSA_GROUPS = 6;
  localparam int CSA_GRP_TEMP = 0;
  localparam int CSA_GRP_RATE = 1;
  localparam int CSA_GRP_ACCEL = 2;
  localparam int CSA_GRP_FIELD = 3;
  localparam int CSA_GRP_QUAT = 4;
  localparam int CSA_GRP_EULER = 5;

  // field positions in control and status words
  localparam int CSA_CTRL_FREEZE_BIT = 0;
  localparam int CSA_STAT_FRESH_LSB = 0;
  localparam int CSA_STAT_MISSED_LSB = 8;
  localparam int CSA_STAT_FREEZE_BIT = 16;

  // reset values and the fill of unused halves
  localparam logic [31:0] CSA_WORD_RST = 32'h0000_0000;
  localparam logic [15:0] CSA_UNUSED_HALF = 16'h0000;
  localparam logic CSA_WAIT_RST = 1'b1;
  localparam logic CSA_FREEZE_RST = 1'b0;

  // fixed-point scale factors applied by the producer of the estimates
  localparam real CSA_QUAT_SCALE = 29789.09091;
  localparam real CSA_ANGLE_SCALE = 91.02222;
  localparam real CSA_RATE_SCALE = 16.0;

  // avalon response codes
  typedef enum logic [1:0] {
    CSA_RSP_OKAY = 2'b00,
    CSA_RSP_SLVERR = 2'b10,
    CSA_RSP_DECERR = 2'b11
  } csa_resp_t;

  // true when the index falls inside the measurement bank
  function automatic logic csa_in_bank(input logic [7:0] idx);
    return (idx >= CSA_IDX_TEMP) && (idx <= CSA_IDX_HEAD_RATE);
  endfunction : csa_in_bank

  // bank slot of an index
  function automatic logic [4:0] csa_slot(input logic [7:0] idx);
    logic [7:0] d;
    d = idx - CSA_IDX_TEMP;
    return d[4:0];
  endfunction : csa_slot

  // measurement group that owns a bank slot
  function automatic logic [2:0] csa_group_of(input logic [4:0] s);
    if (s < csa_slot(CSA_IDX_RATE_X)) return 3'(CSA_GRP_TEMP);
    else if (s < csa_slot(CSA_IDX_ACCEL_X)) return 3'(CSA_GRP_RATE);
    else if (s < csa_slot(CSA_IDX_FIELD_X)) return 3'(CSA_GRP_ACCEL);
    else if (s < csa_slot(CSA_IDX_Q_FIRST)) return 3'(CSA_GRP_FIELD);
    else if (s < csa_slot(CSA_IDX_ROLL_PITCH)) return 3'(CSA_GRP_QUAT);
    else return 3'(CSA_GRP_EULER);
  endfunction : csa_group_of

endpackage : csa_regs_pkg

// file: csa_bank_if.sv
/*
  Carrier between the register front end and the word store: per-word load
  strobes, next words and the stored words.
  Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface csa_bank_if #(
  parameter int WORDS = 21
) (
  input wire logic clk,
  input wire logic rst_n
);
  logic [WORDS-1:0] load; // one strobe per stored word
  logic [WORDS-1:0][31:0] din; // next value per word
  logic [WORDS-1:0][31:0] dout; // stored value per word
  modport fill (input clk, rst_n, dout, output load, din);
  modport store (input clk, rst_n, load, din, output dout);
endinterface : csa_bank_if
`default_nettype wire

// file: csa_word_bank.sv
/*
  Word store of the measurement bank: one 32-bit word per slot, each loaded
  by its own strobe, cleared by reset.
  Assumes synchronous active-low reset delivered through the carrier.
*/
`timescale 1ns/1ps
`default_nettype none
module csa_word_bank #(
  parameter int WORDS = 21
) (
  // carrier to the front end
  csa_bank_if.store bank
);

  logic [31:0] mem_r [WORDS]; // stored words

  // each word loads only on its own strobe, so a group stays whole
  always_ff @(posedge bank.clk) begin
    for (int i = 0; i < WORDS; i++) begin
      if (!bank.rst_n) begin
        mem_r[i] <= csa_regs_pkg::CSA_WORD_RST;
      end else if (bank.load[i]) begin
        mem_r[i] <= bank.din[i];
      end
    end
  end

  // present the store to the front end
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      bank.dout[i] = mem_r[i];
    end
  end

endmodule : csa_word_bank
`default_nettype wire

// file: csa_host_model.sv
/*
  Host model: an avalon-mm master that reads and writes the register bank.
  Assumes the slave answers through waitrequest on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csa_host_model (
  // clock
  input wire logic clk_in,
  // avalon-mm master side
  output logic [9:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  input wire logic [31:0] readdata_in,
  input wire logic waitrequest_in,
  input wire logic [1:0] response_in
);
  // idle bus from time zero
  initial begin
    address_out = 10'h000;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0000_0000;
  end

  // one transfer: request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [9:0] a,
      input logic [31:0] d, output logic [31:0] q,
      output logic [1:0] r, output logic to);
    int n;
    @(posedge clk_in);
    address_out <= a;
    read_out <= ~wr;
    write_out <= wr;
    writedata_out <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_in !== 1'b0 && n < 20);
    // a bounded wait; the bench treats a stuck slave as a fault
    to = (waitrequest_in !== 1'b0);
    q = readdata_in;
    r = response_in;
    read_out <= 1'b0;
    write_out <= 1'b0;
    // released lines turn over so stale values are never trusted
    address_out <= ~a;
    writedata_out <= ~d;
  endtask : xfer
endmodule : csa_host_model
`default_nettype wire

// file: tb_calibrated_sensor_attitude_regs.sv
/*
  Self-checking bench of the measurement and attitude register bank.
  Assumes the host model above and same-clock measurement producers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_calibrated_sensor_attitude_regs;
  logic sys_clk_in = 1'b0; // 50 MHz system clock
  logic reset_n_in = 1'b0; // held low for four cycles
  logic [9:0] adr; // bus wires between host and slave
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic wt;
  logic [1:0] rsp;
  logic [31:0] st [0:20]; // words staged on the producer ports
  logic [31:0] exp_w [0:20]; // expected bank contents
  logic [5:0] vld = 6'h00; // one valid per group
  logic [31:0] seed = 32'hcd9b55ba; // fixed seed keeps runs repeatable
  logic [31:0] q;
  logic [1:0] r;
  int error_cnt = 0;
  int tests_run = 0;
  int lo [0:6] = '{0, 2, 6, 10, 14, 17, 21}; // first slot of each group

  // clock
  always #10 sys_clk_in = ~sys_clk_in;

  csa_attitude_regs u_csa_attitude_regs (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .avs_response_out(rsp),
    .temp_valid_in(vld[0]), .temp_celsius_in(st[0]),
    .temp_stamp_in(st[1]), .rate_valid_in(vld[1]), .rate_x_in(st[2]),
    .rate_y_in(st[3]), .rate_z_in(st[4]), .rate_stamp_in(st[5]),
    .accel_valid_in(vld[2]), .accel_x_in(st[6]), .accel_y_in(st[7]),
    .accel_z_in(st[8]), .accel_stamp_in(st[9]),
    .field_valid_in(vld[3]), .field_x_in(st[10]), .field_y_in(st[11]),
    .field_z_in(st[12]), .field_stamp_in(st[13]),
    .quat_valid_in(vld[4]), .quat_a_in(st[14][31:16]),
    .quat_b_in(st[14][15:0]), .quat_c_in(st[15][31:16]),
    .quat_d_in(st[15][15:0]), .quat_stamp_in(st[16]),
    .euler_valid_in(vld[5]), .roll_angle_in(st[17][31:16]),
    .pitch_angle_in(st[17][15:0]), .heading_angle_in(st[18][31:16]),
    .roll_rate_in(st[19][31:16]), .pitch_rate_in(st[19][15:0]),
    .heading_rate_in(st[20][31:16]));

  csa_host_model u_csa_host_model (
    .clk_in(sys_clk_in), .address_out(adr), .read_out(rd),
    .write_out(wr), .writedata_out(wd), .readdata_in(rdat),
    .waitrequest_in(wt), .response_in(rsp));

  // galois shift register for random words
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction : lfsr

  // expected word: heading slots carry nothing in their low half
  function automatic logic [31:0] expw(input int i, input logic [31:0] v);
    return (i == 18 || i == 20) ? {v[31:16], 16'h0000} : v;
  endfunction : expw

  // verdict and end of run
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one bus transfer at a word index
  task automatic bus(input logic w, input logic [7:0] idx,
      input logic [31:0] d);
    logic to;
    u_csa_host_model.xfer(w, {idx, 2'b00}, d, q, r, to);
    if (to) begin
      error_cnt++;
      conclude();
    end
  endtask : bus

  // read the whole bank and compare with the expected words
  task automatic rd_all();
    for (int i = 0; i < 21; i++) begin
      bus(1'b0, csa_regs_pkg::CSA_IDX_TEMP + 8'(i), 32'h0000_0000);
      chk(q, exp_w[i]);
      chk({30'h0, r}, 32'h0000_0000);
    end
  endtask : rd_all

  // present a whole group for one cycle; a frozen bank keeps the old words
  task automatic load(input int g, input logic frz);
    @(posedge sys_clk_in);
    for (int i = lo[g]; i < lo[g+1]; i++) begin
      seed = lfsr(seed);
      st[i] <= seed;
      if (!frz) exp_w[i] = expw(i, seed);
    end
    vld[g] <= 1'b1;
    @(posedge sys_clk_in);
    vld <= 6'h00;
  endtask : load

  // watchdog against a hang anywhere
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 21; i++) begin
      st[i] = 32'h0000_0000;
      exp_w[i] = 32'h0000_0000;
    end
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd_all();
    repeat (3) begin
      for (int g = 0; g < 6; g++) load(g, 1'b0);
      rd_all();
    end
    // writes to the bank are ignored but answered
    bus(1'b1, csa_regs_pkg::CSA_IDX_RATE_X, 32'hffff_ffff);
    chk({30'h0, r}, 32'h0000_0000);
    bus(1'b1, csa_regs_pkg::CSA_IDX_HEADING, 32'h0000_ffff);
    rd_all();
    // unmapped index answers with a decode error
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk({30'h0, r}, 32'h0000_0003);
    bus(1'b1, 8'h10, 32'h1234_5678);
    chk({30'h0, r}, 32'h0000_0003);
    // freeze: updates dropped, missed bits raised, then unfreeze
    bus(1'b0, csa_regs_pkg::CSA_IDX_STAT, 32'h0000_0000);
    chk(q, 32'h0000_003f);
    bus(1'b1, csa_regs_pkg::CSA_IDX_CTRL, 32'h0000_0001);
    bus(1'b0, csa_regs_pkg::CSA_IDX_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    for (int g = 0; g < 6; g++) load(g, 1'b1);
    // a status write neither clears nor sets the sticky bits
    bus(1'b1, csa_regs_pkg::CSA_IDX_STAT, 32'hffff_ffff);
    chk({30'h0, r}, 32'h0000_0000);
    rd_all();
    bus(1'b0, csa_regs_pkg::CSA_IDX_STAT, 32'h0000_0000);
    chk(q, 32'h0001_3f00);
    bus(1'b1, csa_regs_pkg::CSA_IDX_CTRL, 32'h0000_0000);
    bus(1'b0, csa_regs_pkg::CSA_IDX_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    for (int g = 0; g < 6; g++) load(g, 1'b0);
    rd_all();
    conclude();
  end
endmodule : tb_calibrated_sensor_attitude_regs
`default_nettype wire
